// [rtl/rsh_pkg.sv]
package rsh_pkg;
  // frame constants
  localparam logic [7:0] ADDR_BCAST = 8'h00;
  localparam logic [7:0] ADDR_MAX = 8'hf7;
  localparam logic [7:0] FC_READ = 8'h03;
  localparam logic [7:0] FC_WRITE1 = 8'h06;
  localparam logic [7:0] FC_DIAG = 8'h08;
  localparam logic [7:0] FC_WRITEN = 8'h10;
  localparam logic [7:0] FC_EXC_BIT = 8'h80;
  localparam logic [7:0] INFO_MAX = 8'hcb;
  localparam logic [7:0] WORDS_MAX = 8'h63;
  localparam logic [7:0] PNUM_MAX = 8'h63;
  localparam logic [7:0] EXC_BAD_FC = 8'h01;
  localparam logic [7:0] EXC_BAD_ADDR = 8'h02;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam int READ_REQ_LEN = 8;
  // idle gap for frame boundary, in character times times two
  localparam int GAP_HALF_CHARS = 7;
  localparam int CLK_HZ = 20000000;

  // request summary handed from the receiver to the responder
  typedef struct packed {
    logic [7:0] fc;
    logic [7:0] group;
    logic [7:0] pnum;
    logic [15:0] count;
    logic bcast;
  } rsh_req_s;
endpackage : rsh_pkg

// [rtl/rsh_read_handler.sv]
`timescale 1ns/100ps
module rsh_read_handler #(
  parameter int BAUD = 19200
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] station_id,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic rx_err,
  input wire logic rx_line,
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] par_group,
  output logic [7:0] par_num,
  output logic par_rd,
  input wire logic [15:0] par_data,
  input wire logic par_exists,
  output logic [7:0] wr_fc,
  output logic wr_exec
);
  // gap length: 11 bits per character, 3.5 characters
  localparam int BIT_CYC = rsh_pkg::CLK_HZ / BAUD;
  localparam int GAP_CYC = (rsh_pkg::GAP_HALF_CHARS * 11 * BIT_CYC + 1) / 2;

  typedef enum {S_RX, S_CHECK, S_HDR, S_FETCH, S_DATA, S_CRC, S_DROP} rsh_state_e;
  rsh_state_e state_q;

  logic [7:0] buf_q [0:207];
  logic [7:0] len_q;
  logic [7:0] need_q;
  logic bad_q;
  logic [15:0] crc_q;
  logic [2:0] line_q;
  logic [20:0] gap_q;
  logic frame_end;
  rsh_pkg::rsh_req_s req_q;
  logic [7:0] exc_q;
  logic [7:0] hidx_q;
  logic [7:0] words_q;
  logic [15:0] word_q;
  logic [15:0] txcrc_q;
  logic lo_q;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
    begin
      r = r[0] ? ((r >> 1) ^ rsh_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_step

  // line idle detector on synchronised pin
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      line_q <= 3'h7;
      gap_q <= '0;
    end
    else
    begin
      line_q <= {line_q[1:0], rx_line};
      if (rx_valid || (line_q[2] != line_q[1]) || !line_q[1])
        gap_q <= '0;
      else if (gap_q != 21'(GAP_CYC))
        gap_q <= gap_q + 21'h1;
    end
  end
  assign frame_end = (gap_q == 21'(GAP_CYC - 1));

  // expected length from function code and byte count
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      need_q <= 8'hff;
    else if (state_q != S_RX || frame_end)
      need_q <= 8'hff;
    else if (rx_valid && len_q == 8'h01)
      need_q <= (rx_data == rsh_pkg::FC_WRITEN || rx_data[7]) ? 8'hff : 8'h08;
    else if (rx_valid && len_q == 8'h06 && buf_q[1] == rsh_pkg::FC_WRITEN)
      need_q <= rx_data + 8'h09;
  end

  // receive, crc accumulate, length check
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      len_q <= '0;
      bad_q <= 1'b0;
      crc_q <= rsh_pkg::CRC_INIT;
    end
    else if (state_q == S_RX)
    begin
      if (frame_end)
      begin
        len_q <= '0;
        bad_q <= 1'b0;
        crc_q <= rsh_pkg::CRC_INIT;
      end
      else if (rx_valid)
      begin
        if (len_q < 8'hd0)
        begin
          buf_q[len_q] <= rx_data;
          len_q <= len_q + 8'h1;
        end
        else
          bad_q <= 1'b1;
        crc_q <= crc_step(crc_q, rx_data);
        if (rx_err)
          bad_q <= 1'b1;
      end
    end
  end

  // request decode and validation
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      req_q <= '0;
      exc_q <= '0;
    end
    else if (state_q == S_CHECK)
    begin
      req_q.fc <= buf_q[1];
      req_q.group <= buf_q[2];
      req_q.pnum <= buf_q[3];
      req_q.count <= {buf_q[4], buf_q[5]};
      req_q.bcast <= (buf_q[0] == rsh_pkg::ADDR_BCAST);
      exc_q <= 8'h00;
      if (!(buf_q[1] inside {rsh_pkg::FC_READ, rsh_pkg::FC_WRITE1,
                             rsh_pkg::FC_DIAG, rsh_pkg::FC_WRITEN}))
        exc_q <= rsh_pkg::EXC_BAD_FC;
      else if (buf_q[1] == rsh_pkg::FC_READ &&
               (!(buf_q[2] inside {[8'h00:8'h09], 8'h0b, [8'h1e:8'h27], 8'h29, 8'h2a}) ||
                buf_q[3] > rsh_pkg::PNUM_MAX))
        exc_q <= rsh_pkg::EXC_BAD_ADDR;
      else if (buf_q[1] == rsh_pkg::FC_READ &&
               (buf_q[4] != 8'h00 || buf_q[5] == 8'h00 || buf_q[5] > rsh_pkg::WORDS_MAX ||
                ({1'b0, buf_q[3]} + {1'b0, buf_q[5]}) > 9'h064))
        exc_q <= rsh_pkg::EXC_BAD_ADDR;
    end
  end

  // accepted frame check
  logic frame_ok;
  assign frame_ok = !bad_q && len_q >= 8'h04 && crc_q == 16'h0000 &&
                    (len_q == need_q || need_q == 8'hff) &&
                    buf_q[0] <= rsh_pkg::ADDR_MAX &&
                    (buf_q[0] == station_id || buf_q[0] == rsh_pkg::ADDR_BCAST);

  // main sequencer
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      state_q <= S_RX;
    else
    begin
      unique case (state_q)
        S_RX:
          if (frame_end && len_q != 8'h00)
            state_q <= frame_ok ? S_CHECK : S_RX;
        S_CHECK:
          state_q <= (buf_q[0] == rsh_pkg::ADDR_BCAST) ? S_DROP : S_HDR;
        S_HDR:
          // write and diagnostic replies stop after station and function code
          if (tx_ready && (hidx_q == 8'h02 ||
                           (hidx_q == 8'h01 && exc_q == 8'h00 && req_q.fc != rsh_pkg::FC_READ)))
            state_q <= (exc_q != 8'h00 || req_q.fc != rsh_pkg::FC_READ) ? S_CRC : S_FETCH;
        S_FETCH:
          state_q <= S_DATA;
        S_DATA:
          if (tx_ready && lo_q)
            state_q <= (words_q == 8'h01) ? S_CRC : S_FETCH;
        S_CRC:
          if (tx_ready && lo_q)
            state_q <= S_RX;
        S_DROP:
          state_q <= S_RX;
      endcase
    end
  end

  // write and diagnostic functions are handed out on a strobe, broadcast included
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      wr_exec <= 1'b0;
      wr_fc <= '0;
    end
    else
    begin
      // exc_q still holds the previous frame's verdict here, so decode the code itself
      wr_exec <= (state_q == S_CHECK) &&
                 buf_q[1] inside {rsh_pkg::FC_WRITE1, rsh_pkg::FC_DIAG, rsh_pkg::FC_WRITEN};
      if (state_q == S_CHECK)
        wr_fc <= buf_q[1];
    end
  end

  // parameter fetch, missing ones read as zero
  assign par_group = req_q.group;
  assign par_rd = (state_q == S_FETCH);
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      par_num <= '0;
      words_q <= '0;
      word_q <= '0;
    end
    else if (state_q == S_CHECK)
    begin
      par_num <= buf_q[3];
      words_q <= buf_q[5];
    end
    else if (state_q == S_FETCH)
      word_q <= par_exists ? par_data : 16'h0000;
    else if (state_q == S_DATA && tx_ready && lo_q)
    begin
      par_num <= par_num + 8'h01;
      words_q <= words_q - 8'h01;
    end
  end

  // transmit byte selection
  always_comb
  begin
    tx_valid = state_q inside {S_HDR, S_DATA, S_CRC};
    tx_data = 8'h00;
    unique case (state_q)
      S_HDR:
        if (hidx_q == 8'h00)
          tx_data = station_id;
        else if (hidx_q == 8'h01)
          tx_data = (exc_q != 8'h00) ? (req_q.fc | rsh_pkg::FC_EXC_BIT) : req_q.fc;
        else
          tx_data = (exc_q != 8'h00) ? exc_q : {req_q.count[6:0], 1'b0};
      S_DATA:
        tx_data = lo_q ? word_q[7:0] : word_q[15:8];
      S_CRC:
        tx_data = lo_q ? txcrc_q[15:8] : txcrc_q[7:0];
      default:
        tx_data = 8'h00;
    endcase
  end

  // transmit counters and running crc
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      hidx_q <= '0;
      lo_q <= 1'b0;
      txcrc_q <= rsh_pkg::CRC_INIT;
    end
    else if (state_q == S_CHECK)
    begin
      hidx_q <= '0;
      lo_q <= 1'b0;
      txcrc_q <= rsh_pkg::CRC_INIT;
    end
    else if (tx_valid && tx_ready)
    begin
      if (state_q != S_CRC)
        txcrc_q <= crc_step(txcrc_q, tx_data);
      if (state_q == S_HDR)
        hidx_q <= hidx_q + 8'h01;
      else
        lo_q <= !lo_q;
      if (state_q == S_HDR && hidx_q == 8'h02)
        lo_q <= 1'b0;
    end
  end

  // reply never leaves for a broadcast
  a_no_bcast_reply: assert property (@(posedge sys_clk) disable iff (rst)
    (state_q == S_CHECK && buf_q[0] == rsh_pkg::ADDR_BCAST) |=> !tx_valid [*2])
    else $error("reply started for broadcast");
  a_bad_crc_drop: assert property (@(posedge sys_clk) disable iff (rst)
    (state_q == S_RX && frame_end && crc_q != 16'h0000) |=> state_q == S_RX)
    else $error("bad crc frame accepted");
  a_exc_fc_bit: assert property (@(posedge sys_clk) disable iff (rst)
    (state_q == S_HDR && hidx_q == 8'h01 && exc_q != 8'h00) |-> tx_data[7])
    else $error("error reply lacks exception bit");
  a_bad_fc_code: assert property (@(posedge sys_clk) disable iff (rst)
    (state_q == S_CHECK && buf_q[1] == 8'h04) |=> exc_q == rsh_pkg::EXC_BAD_FC)
    else $error("unsupported function not flagged");
  a_count_limit: assert property (@(posedge sys_clk) disable iff (rst)
    (state_q == S_CHECK && buf_q[1] == rsh_pkg::FC_READ && buf_q[5] > 8'h63) |=> exc_q != 8'h00)
    else $error("oversize read accepted");
  a_group_gap: assert property (@(posedge sys_clk) disable iff (rst)
    (state_q == S_CHECK && buf_q[1] == rsh_pkg::FC_READ && buf_q[2] == 8'h28) |=>
    exc_q == rsh_pkg::EXC_BAD_ADDR)
    else $error("group 40 accepted");
  a_missing_zero: assert property (@(posedge sys_clk) disable iff (rst)
    (state_q == S_FETCH && !par_exists) |=> word_q == 16'h0000)
    else $error("missing parameter not zero");
  a_foreign_drop: assert property (@(posedge sys_clk) disable iff (rst)
    (state_q == S_RX && frame_end && buf_q[0] != station_id && buf_q[0] != 8'h00) |=>
    state_q == S_RX)
    else $error("foreign station frame accepted");
  a_ascending: assert property (@(posedge sys_clk) disable iff (rst)
    (state_q == S_DATA && tx_ready && lo_q && words_q != 8'h01) |=> par_num == $past(par_num) + 8'h01)
    else $error("parameter order broken");
  c_read_reply: cover property (@(posedge sys_clk) state_q == S_DATA && tx_ready);
  c_error_reply: cover property (@(posedge sys_clk) state_q == S_HDR && exc_q != 8'h00);
  c_broadcast: cover property (@(posedge sys_clk) state_q == S_DROP);
  a_write_strobe: assert property (@(posedge sys_clk) disable iff (rst)
    (state_q == S_CHECK && buf_q[1] == rsh_pkg::FC_WRITE1) |=> wr_exec)
    else $error("write function not handed out");
  c_write_exec: cover property (@(posedge sys_clk) wr_exec && req_q.bcast);
  c_long_read: cover property (@(posedge sys_clk) state_q == S_FETCH && words_q == 8'h63);
endmodule : rsh_read_handler

// [test/rsh_host_model.sv]
`timescale 1ns/100ps
// host side sink for reply bytes, stalls at random when asked to
module rsh_host_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic stall_en,
  output logic tx_ready
);
  // a new ready level just after each edge, about one cycle in three refused
  always @(posedge sys_clk)
  begin
    tx_ready <= #1 rst | !stall_en | ($urandom % 3 != 0);
  end
endmodule : rsh_host_model

// [test/rtu_slave_read_handler_bench.sv]
`timescale 1ns/100ps
module rtu_slave_read_handler_bench;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] rx_data = 8'h00;
  logic rx_valid = 1'b0;
  logic rx_err = 1'b0;
  logic rx_line = 1'b1;
  logic stall_en = 1'b0;
  logic [7:0] tx_data, par_group, par_num, wr_fc;
  logic tx_valid, tx_ready, par_rd, wr_exec, par_exists;
  logic [15:0] par_data;
  logic [7:0] exp_q[$];
  int fails = 0;
  int n_tests = 0;
  int n_exec = 0;
  int e0;
  int n_rd = 0;
  logic [7:0] exp_fc = 8'h00;
  int grp_list[10] = '{0, 9, 10, 11, 12, 29, 30, 40, 42, 43};
  int fc_list[7] = '{0, 2, 4, 7, 9, 17, 127};
  int rnd_list[10] = '{0, 1, 5, 9, 11, 30, 35, 39, 41, 42};
  logic [7:0] g, n;

  initial forever #25 sys_clk = ~sys_clk;

  rsh_read_handler #(.BAUD(2000000)) DUT (.sys_clk(sys_clk), .rst(rst), .station_id(8'h0c),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_err(rx_err), .rx_line(rx_line),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .par_group(par_group),
    .par_num(par_num), .par_rd(par_rd), .par_data(par_data), .par_exists(par_exists),
    .wr_fc(wr_fc), .wr_exec(wr_exec));
  rsh_host_model host (.sys_clk(sys_clk), .rst(rst), .stall_en(stall_en), .tx_ready(tx_ready));

  // parameter store: every fifth number from 3 on is missing, raw data still nonzero
  assign par_exists = (par_num % 8'h05) != 8'h03;
  assign par_data = {par_group ^ 8'h5a, par_num};

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test

  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i])
    begin
      c ^= {8'h00, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction : crc16

  // note a reply, crc low byte first
  task automatic expect_reply(input logic [7:0] r[$]);
    logic [15:0] c;
    c = crc16(r);
    exp_q = {exp_q, r, c[7:0], c[15:8]};
  endtask : expect_reply

  // send one frame, optionally with a broken crc or a receive error on byte 2
  task automatic send(input logic [7:0] f[$], input bit bad, input bit err);
    logic [15:0] c;
    c = crc16(f) ^ {15'h0000, bad};
    f = {f, c[7:0], c[15:8]};
    foreach (f[i])
    begin
      @(posedge sys_clk);
      #1;
      rx_line = 1'b0;
      rx_data = f[i];
      rx_valid = 1'b1;
      rx_err = err && i == 2;
      @(posedge sys_clk);
      #1;
      rx_valid = 1'b0;
      rx_err = 1'b0;
      @(posedge sys_clk);
    end
    #1 rx_line = 1'b1;
    for (int k = 0; k < 4000 && exp_q.size() > 0; k++)
      @(posedge sys_clk);
    repeat (800) @(posedge sys_clk);
    check(16'(exp_q.size()), 16'h0000);
  endtask : send

  task automatic rd(input logic [7:0] g, input logic [7:0] n, input logic [15:0] cnt);
    logic [7:0] r[$];
    logic [15:0] w;
    bit ok;
    int r0;
    ok = (g <= 9 || g == 11 || (g >= 30 && g <= 42 && g != 40)) && cnt >= 1 && cnt <= 99 &&
         n + cnt <= 100;
    r = {8'h0c, ok ? 8'h03 : 8'h83, ok ? 8'(2 * cnt) : 8'h02};
    for (int i = 0; ok && i < cnt; i++)
    begin
      w = ((n + i) % 5 == 3) ? 16'h0000 : {g ^ 8'h5a, 8'(n + i)};
      r.push_back(w[15:8]);
      r.push_back(w[7:0]);
    end
    expect_reply(r);
    r0 = n_rd;
    send({8'h0c, 8'h03, g, n, cnt[15:8], cnt[7:0]}, 1'b0, 1'b0);
    check(16'(n_rd - r0), ok ? cnt : 16'h0000);
  endtask : rd

  // each taken reply byte against the oldest note
  always @(posedge sys_clk)
  begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1)
    begin
      check(16'(exp_q.size() > 0), 16'h0001);
      if (exp_q.size() > 0)
        check({8'h00, tx_data}, {8'h00, exp_q.pop_front()});
    end
    if (par_rd === 1'b1)
      n_rd++;
    if (wr_exec === 1'b1)
    begin
      n_exec++;
      check({8'h00, wr_fc}, {8'h00, exp_fc});
    end
  end

  // watchdog
  initial
  begin
    #4000000;
    fails++;
    end_of_test();
  end

  initial
  begin
    void'($urandom(32'h2066));
    repeat (4) @(posedge sys_clk);
    #1 rst = 1'b0;
    rd(8'h00, 8'h05, 16'h0001);
    stall_en = 1'b1;
    rd(8'h2a, 8'h00, 16'h0063);
    foreach (grp_list[i])
      rd(8'(grp_list[i]), 8'h03, 16'h0002);
    rd(8'h01, 8'h62, 16'h0003);
    rd(8'h01, 8'h63, 16'h0001);
    rd(8'h01, 8'h00, 16'h0000);
    rd(8'h01, 8'h00, 16'h0100);
    rd(8'h01, 8'h00, 16'h0064);
    foreach (fc_list[i])
    begin
      g = 8'(fc_list[i]);
      expect_reply({8'h0c, g | 8'h80, 8'h01});
      send({8'h0c, g, 8'h00, 8'h00, 8'h00, 8'h01}, 1'b0, 1'b0);
    end
    send({8'h0c, 8'h03, 8'h00, 8'h01, 8'h00, 8'h01}, 1'b1, 1'b0);
    send({8'h0c, 8'h03, 8'h00, 8'h01, 8'h00, 8'h01}, 1'b0, 1'b1);
    send({8'h0d, 8'h03, 8'h00, 8'h01, 8'h00, 8'h01}, 1'b0, 1'b0);
    e0 = n_exec;
    exp_fc = 8'h06;
    expect_reply({8'h0c, 8'h06});
    send({8'h0c, 8'h06, 8'h00, 8'h01, 8'h00, 8'h05}, 1'b0, 1'b0);
    exp_fc = 8'h08;
    expect_reply({8'h0c, 8'h08});
    send({8'h0c, 8'h08, 8'h00, 8'h00, 8'h00, 8'h11}, 1'b0, 1'b0);
    exp_fc = 8'h06;
    send({8'h00, 8'h06, 8'h00, 8'h01, 8'h00, 8'h05}, 1'b0, 1'b0);
    exp_fc = 8'h10;
    send({8'h00, 8'h10, 8'h00, 8'h01, 8'h00, 8'h01, 8'h02, 8'h12, 8'h34}, 1'b0, 1'b0);
    check(16'(n_exec - e0), 16'h0004);
    repeat (6)
    begin
      g = 8'(rnd_list[$urandom % 10]);
      n = 8'($urandom % 100);
      rd(g, n, 16'(1 + $urandom % (100 - n)));
    end
    end_of_test();
  end
endmodule : rtu_slave_read_handler_bench
